// *** logic/gdt_params.svh ***
// Purpose: constants of the gate-drive timing configuration bank
// Assumes: 10 MHz core clock
// Notes: offsets are register addresses of the decoded serial write port
`ifndef GDT_PARAMS_SVH
`define GDT_PARAMS_SVH

// ==========================================================
// register addresses and bank bit
`define GDT_ADDR_PWM 4'h3
`define GDT_ADDR_CAL 4'h4
`define GDT_ADDR_CH1 4'h5
`define GDT_BANK_BIT 10

// ==========================================================
// field positions, pwm source register
`define GDT_PWM_FIELDS_LOW 5
// calibration control
`define GDT_CAL_DLY_LSB 7
`define GDT_CAL_PC_LSB 3
`define GDT_CAL_SEL_LSB 0
// configuration a
`define GDT_BLANK_LSB 8
`define GDT_IPCF_LSB 5
`define GDT_IPCR_LSB 2
`define GDT_TPC_LSB 0

// ==========================================================
// reset values, and the split-output select code
`define GDT_PWM_SEL_RST 2'h0
`define GDT_CAL_CODE_RST 4'h0
`define GDT_CAL_SEL_RST 3'h0
`define GDT_BLANK_RST 2'h0
`define GDT_CURRENT_RST 3'h0
`define GDT_TPC_RST 2'h0
`define GDT_CAL_SEL_SPLIT 3'h7

// ==========================================================
// timing, in ns, and the clock period
`define GDT_CLK_PERIOD_NS 100
`define GDT_CAL_DLY_BASE_NS 350
`define GDT_CAL_DLY_STEP_NS 200
`define GDT_CAL_PC_BASE_NS 50
`define GDT_CAL_PC_STEP_NS 100
`define GDT_BLANK_STEP_NS 1000
`define GDT_TPC_STEP_NS 100

`endif

// *** logic/gdt_pkg.sv ***
// Purpose: field types of the gate-drive timing configuration bank
// Assumes: nothing
// Notes: constants live in gdt_params.svh
`default_nettype none

package gdt_pkg;
  typedef logic [3:0] gdt_addr_t;
  typedef logic [10:0] gdt_word_t;
  typedef logic [1:0] gdt_pwm_sel_t;
  typedef logic [3:0] gdt_cal_code_t;
  typedef logic [2:0] gdt_cal_sel_t;
  typedef logic [1:0] gdt_blank_t;
  typedef logic [2:0] gdt_current_t;
  typedef logic [1:0] gdt_pc_time_t;
endpackage

`default_nettype wire

// *** logic/gdt_channel.sv ***
// Purpose: one half-bridge channel: pwm source and configuration a fields
// Assumes: writes are already decoded for this channel
// Notes: pwm output is registered, one cycle behind the inputs
`timescale 1ns/10ps
`default_nettype none
`include "gdt_params.svh"

module gdt_channel #(
  parameter int unsigned N_PWM = 4
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // decoded writes
  input wire logic cfg_wr_in,
  input wire gdt_pkg::gdt_word_t cfg_data_in,
  input wire logic sel_wr_in,
  input wire gdt_pkg::gdt_pwm_sel_t sel_data_in,
  // pwm inputs
  input wire logic [N_PWM-1:0] pwm_inputs_in,
  // fields and derived timing
  output logic chan_pwm_out,
  output gdt_pkg::gdt_pwm_sel_t pwm_source_select_out,
  output gdt_pkg::gdt_blank_t cross_conduction_blank_time_out,
  output gdt_pkg::gdt_current_t fall_precharge_current_out,
  output gdt_pkg::gdt_current_t rise_precharge_current_out,
  output gdt_pkg::gdt_pc_time_t slope_precharge_time_out,
  output logic [5:0] blank_cycles_out,
  output logic [2:0] precharge_cycles_out
);
  import gdt_pkg::*;

  // ==========================================================
  // field extraction
  wire gdt_blank_t blank_nxt = cfg_data_in[`GDT_BLANK_LSB +: 2];
  wire gdt_current_t ipcf_nxt = cfg_data_in[`GDT_IPCF_LSB +: 3];
  wire gdt_current_t ipcr_nxt = cfg_data_in[`GDT_IPCR_LSB +: 3];
  wire gdt_pc_time_t tpc_nxt = cfg_data_in[`GDT_TPC_LSB +: 2];
  wire logic [5:0] blank_cyc_nxt =
    6'((32'(blank_nxt) + 1) * `GDT_BLANK_STEP_NS / `GDT_CLK_PERIOD_NS);
  wire logic [2:0] pc_cyc_nxt =
    3'((32'(tpc_nxt) + 1) * `GDT_TPC_STEP_NS / `GDT_CLK_PERIOD_NS);
  // out-of-range select code cannot occur with four inputs
  wire logic pwm_nxt = pwm_inputs_in[pwm_source_select_out];

  // ==========================================================
  // registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pwm_source_select_out <= `GDT_PWM_SEL_RST;
      chan_pwm_out <= 1'b0;
    end else begin
      if (sel_wr_in) begin
        pwm_source_select_out <= sel_data_in;
      end
      chan_pwm_out <= pwm_nxt;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cross_conduction_blank_time_out <= `GDT_BLANK_RST;
      fall_precharge_current_out <= `GDT_CURRENT_RST;
      rise_precharge_current_out <= `GDT_CURRENT_RST;
      slope_precharge_time_out <= `GDT_TPC_RST;
      blank_cycles_out <= 6'((`GDT_BLANK_STEP_NS) / `GDT_CLK_PERIOD_NS);
      precharge_cycles_out <= 3'((`GDT_TPC_STEP_NS) / `GDT_CLK_PERIOD_NS);
    end else if (cfg_wr_in) begin
      cross_conduction_blank_time_out <= blank_nxt;
      fall_precharge_current_out <= ipcf_nxt;
      rise_precharge_current_out <= ipcr_nxt;
      slope_precharge_time_out <= tpc_nxt;
      blank_cycles_out <= blank_cyc_nxt;
      precharge_cycles_out <= pc_cyc_nxt;
    end
  end

  // ==========================================================
  // assertions
  AST_BLANK_TIME: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cfg_wr_in |=> blank_cycles_out == 6'd10 * (6'(cross_conduction_blank_time_out) + 6'd1))
    else $error("blank cycles do not match blanking code");
  AST_FALL_CURRENT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cfg_wr_in |=> fall_precharge_current_out == $past(cfg_data_in[7:5]))
    else $error("falling pre-charge current not taken from write");
  AST_RISE_CURRENT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cfg_wr_in |=> rise_precharge_current_out == $past(cfg_data_in[4:2]))
    else $error("rising pre-charge current not taken from write");
  AST_PC_TIME: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cfg_wr_in |=> precharge_cycles_out == 3'(slope_precharge_time_out) + 3'd1)
    else $error("pre-charge cycles do not match time code");
  AST_CH_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !cfg_wr_in |=> $stable(cross_conduction_blank_time_out) && $stable(slope_precharge_time_out))
    else $error("channel settings changed without a write to this channel");
endmodule

`default_nettype wire

// *** logic/gdt_config_top.sv ***
// Purpose: gate-drive timing configuration bank of a seven-channel pre-driver
// Assumes: serial frames are decoded upstream into address, data and a write strobe
// Notes: configuration b words (bank bit set) at the channel addresses are ignored here
`timescale 1ns/10ps
`default_nettype none
`include "gdt_params.svh"

module gdt_config_top #(
  parameter int unsigned N_CHAN = 7,
  parameter int unsigned N_PWM = 4
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // decoded register write
  input wire logic reg_wr_in,
  input wire gdt_pkg::gdt_addr_t reg_addr_in,
  input wire gdt_pkg::gdt_word_t reg_data_in,
  // pwm inputs, one to four
  input wire logic [N_PWM-1:0] pwm_inputs_in,
  // per-channel routed pwm
  output logic [N_CHAN-1:0] chan_pwm_out,
  // calibration unit setup
  output gdt_pkg::gdt_cal_code_t cal_slope_end_delay_out,
  output gdt_pkg::gdt_cal_code_t cal_precharge_time_out,
  output gdt_pkg::gdt_cal_sel_t cal_output_select_out,
  output logic cal_enable_out,
  output logic [N_CHAN-1:0] cal_target_out,
  output logic [5:0] cal_delay_cycles_out,
  output logic [4:0] cal_precharge_cycles_out,
  // per-channel pwm source and configuration a, flattened by channel
  output logic [2*N_CHAN-1:0] pwm_source_select_out,
  output logic [2*N_CHAN-1:0] cross_conduction_blank_time_out,
  output logic [3*N_CHAN-1:0] fall_precharge_current_out,
  output logic [3*N_CHAN-1:0] rise_precharge_current_out,
  output logic [2*N_CHAN-1:0] slope_precharge_time_out,
  output logic [6*N_CHAN-1:0] blank_cycles_out,
  output logic [3*N_CHAN-1:0] precharge_cycles_out
);
  import gdt_pkg::*;

  // ==========================================================
  // reset release
  logic [1:0] rst_sync_r;
  wire logic rst_n = rst_sync_r[1];

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  // ==========================================================
  // write decode
  wire logic bank_b = reg_data_in[`GDT_BANK_BIT];
  wire logic pwm_a_wr = reg_wr_in && (reg_addr_in == `GDT_ADDR_PWM) && !bank_b;
  wire logic pwm_b_wr = reg_wr_in && (reg_addr_in == `GDT_ADDR_PWM) && bank_b;
  wire logic cal_wr = reg_wr_in && (reg_addr_in == `GDT_ADDR_CAL);

  // ==========================================================
  // calibration control
  wire gdt_cal_code_t cal_dly_nxt = reg_data_in[`GDT_CAL_DLY_LSB +: 4];
  wire gdt_cal_code_t cal_pc_nxt = reg_data_in[`GDT_CAL_PC_LSB +: 4];
  wire gdt_cal_sel_t cal_sel_nxt = reg_data_in[`GDT_CAL_SEL_LSB +: 3];
  // least times, so rounded up to whole cycles
  wire logic [5:0] cal_dly_cyc_nxt = 6'((`GDT_CAL_DLY_BASE_NS
    + `GDT_CAL_DLY_STEP_NS * 32'(cal_dly_nxt) + `GDT_CLK_PERIOD_NS - 1)
    / `GDT_CLK_PERIOD_NS);
  wire logic [4:0] cal_pc_cyc_nxt = 5'((`GDT_CAL_PC_BASE_NS
    + `GDT_CAL_PC_STEP_NS * 32'(cal_pc_nxt) + `GDT_CLK_PERIOD_NS - 1)
    / `GDT_CLK_PERIOD_NS);
  // code n selects bridge n; code 7 lands on the channel-seven split output
  wire logic [N_CHAN-1:0] cal_target_nxt = (cal_sel_nxt == `GDT_CAL_SEL_RST) ?
    '0 : N_CHAN'(1) << (cal_sel_nxt - 3'h1);

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cal_slope_end_delay_out <= `GDT_CAL_CODE_RST;
      cal_precharge_time_out <= `GDT_CAL_CODE_RST;
      cal_output_select_out <= `GDT_CAL_SEL_RST;
      cal_enable_out <= 1'b0;
      cal_target_out <= '0;
      cal_delay_cycles_out <= 6'((`GDT_CAL_DLY_BASE_NS + `GDT_CLK_PERIOD_NS - 1)
        / `GDT_CLK_PERIOD_NS);
      cal_precharge_cycles_out <= 5'((`GDT_CAL_PC_BASE_NS + `GDT_CLK_PERIOD_NS - 1)
        / `GDT_CLK_PERIOD_NS);
    end else if (cal_wr) begin
      cal_slope_end_delay_out <= cal_dly_nxt;
      cal_delay_cycles_out <= cal_dly_cyc_nxt;
      cal_precharge_time_out <= cal_pc_nxt;
      cal_precharge_cycles_out <= cal_pc_cyc_nxt;
      cal_output_select_out <= cal_sel_nxt;
      cal_enable_out <= (cal_sel_nxt != `GDT_CAL_SEL_RST);
      cal_target_out <= cal_target_nxt;
    end
  end

  // ==========================================================
  // channels
  // host keeps the bridge tri-stated and steps pre-charge codes singly;
  // no interlock here, settings take effect on the write itself
  for (genvar ch = 0; ch < N_CHAN; ch++) begin : g_chan
    localparam int unsigned SLOT = (ch < `GDT_PWM_FIELDS_LOW) ? ch : ch - `GDT_PWM_FIELDS_LOW;
    wire logic cfg_wr = reg_wr_in && !bank_b
      && (reg_addr_in == 4'(`GDT_ADDR_CH1 + ch));
    wire logic sel_wr = (ch < `GDT_PWM_FIELDS_LOW) ? pwm_a_wr : pwm_b_wr;
    wire gdt_pwm_sel_t sel_data = reg_data_in[2*SLOT +: 2];

    gdt_channel #(
      .N_PWM(N_PWM)
    ) u_chan (
      .clk_in(core_clk_in),
      .rst_n_in(rst_n),
      .cfg_wr_in(cfg_wr),
      .cfg_data_in(reg_data_in),
      .sel_wr_in(sel_wr),
      .sel_data_in(sel_data),
      .pwm_inputs_in(pwm_inputs_in),
      .chan_pwm_out(chan_pwm_out[ch]),
      .pwm_source_select_out(pwm_source_select_out[2*ch +: 2]),
      .cross_conduction_blank_time_out(cross_conduction_blank_time_out[2*ch +: 2]),
      .fall_precharge_current_out(fall_precharge_current_out[3*ch +: 3]),
      .rise_precharge_current_out(rise_precharge_current_out[3*ch +: 3]),
      .slope_precharge_time_out(slope_precharge_time_out[2*ch +: 2]),
      .blank_cycles_out(blank_cycles_out[6*ch +: 6]),
      .precharge_cycles_out(precharge_cycles_out[3*ch +: 3])
    );
  end

  // ==========================================================
  // assertions
  AST_PWM_ROUTE: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    $stable(pwm_source_select_out[1:0]) |=> chan_pwm_out[0]
      == $past(pwm_inputs_in[pwm_source_select_out[1:0]]))
    else $error("channel one pwm not taken from selected input");
  AST_PWM_A_LOW: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    pwm_a_wr |=> pwm_source_select_out[9:8] == $past(reg_data_in[9:8]))
    else $error("channel five pwm source not written from low word");
  AST_PWM_B_HIGH: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    pwm_b_wr |=> pwm_source_select_out[13:12] == $past(reg_data_in[3:2]))
    else $error("channel seven pwm source not written from high word");
  AST_CAL_DLY: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    cal_wr |=> cal_delay_cycles_out == 6'd4 + 6'd2 * 6'(cal_slope_end_delay_out))
    else $error("slope-end delay cycles wrong");
  AST_CAL_PC: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    cal_wr |=> cal_precharge_cycles_out == 5'(cal_precharge_time_out) + 5'd1)
    else $error("calibration pre-charge cycles wrong");
  AST_CAL_OFF: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (cal_output_select_out == 3'h0) |-> !cal_enable_out && (cal_target_out == '0))
    else $error("calibration unit active with select code zero");
  AST_CAL_SPLIT: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (cal_output_select_out == `GDT_CAL_SEL_SPLIT) |-> cal_target_out[N_CHAN-1] && cal_enable_out)
    else $error("select code seven does not reach the split output");
  AST_CH_ONLY_OWN: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (reg_wr_in && reg_addr_in == `GDT_ADDR_CH1) |=> $stable(cross_conduction_blank_time_out[13:2]))
    else $error("write to channel one changed another channel");
  // fields come straight from the word and hold until their own register is written
  AST_PWM_A_CH1: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    pwm_a_wr |=> pwm_source_select_out[1:0] == $past(reg_data_in[1:0]))
    else $error("channel one pwm source not written from low word");
  AST_PWM_B_CH6: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    pwm_b_wr |=> pwm_source_select_out[11:10] == $past(reg_data_in[1:0]))
    else $error("channel six pwm source not written from high word");
  AST_PWM_HOLD: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    !(pwm_a_wr || pwm_b_wr) |=> $stable(pwm_source_select_out))
    else $error("pwm sources changed without a source write");
  // the last channel checked too, as it takes its source from the high word
  AST_PWM_ROUTE_CH7: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    rst_n |=> chan_pwm_out[6] == $past(pwm_inputs_in[pwm_source_select_out[13:12]]))
    else $error("channel seven pwm not taken from selected input");
  AST_CAL_DLY_TAKEN: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    cal_wr |=> cal_slope_end_delay_out == $past(reg_data_in[10:7]))
    else $error("slope-end delay code not taken from write");
  AST_CAL_PC_TAKEN: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    cal_wr |=> cal_precharge_time_out == $past(reg_data_in[6:3]))
    else $error("calibration pre-charge code not taken from write");
  AST_CAL_SEL_TAKEN: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    cal_wr |=> cal_output_select_out == $past(reg_data_in[2:0]))
    else $error("calibration select code not taken from write");
  AST_CAL_TARGET: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (cal_output_select_out != 3'h0)
      |-> cal_enable_out && (cal_target_out == N_CHAN'(1) << (cal_output_select_out - 3'h1)))
    else $error("calibration unit not attached to the selected bridge");
  AST_CAL_HOLD: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    !cal_wr |=> $stable(cal_slope_end_delay_out) && $stable(cal_precharge_time_out))
    else $error("calibration codes changed without a calibration write");
  AST_CFG_B_REFUSED: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (reg_wr_in && bank_b && reg_addr_in != `GDT_ADDR_PWM) |=> $stable(fall_precharge_current_out))
    else $error("configuration b word changed a configuration a field");
  AST_CH1_TAKEN: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    g_chan[0].cfg_wr |=> cross_conduction_blank_time_out[1:0] == $past(reg_data_in[9:8]))
    else $error("channel one blanking code not taken from write");
  AST_CH7_OWN: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    g_chan[6].cfg_wr |=> $stable(slope_precharge_time_out[11:0]))
    else $error("write to channel seven changed another channel");

  COV_CAL_SPLIT: cover property (@(posedge core_clk_in) disable iff (!rst_n)
    cal_wr && reg_data_in[2:0] == 3'h7);
  COV_CH7_CFG: cover property (@(posedge core_clk_in) disable iff (!rst_n)
    reg_wr_in && reg_addr_in == 4'hb && !bank_b);
  COV_PWM_B: cover property (@(posedge core_clk_in) disable iff (!rst_n) pwm_b_wr);
  COV_PWM_A: cover property (@(posedge core_clk_in) disable iff (!rst_n) pwm_a_wr);
  COV_CFG_B: cover property (@(posedge core_clk_in) disable iff (!rst_n)
    reg_wr_in && bank_b && reg_addr_in == `GDT_ADDR_CH1);
endmodule

`default_nettype wire

// *** dv/gdt_host_model.sv ***
// Purpose: host model issuing decoded register writes to the bank
// Assumes: requests launched on the falling clock edge
// Notes: released bus lines show the inverse of the last word
`timescale 1ns/10ps
`default_nettype none

module gdt_host_model (
  // clock
  input wire logic clk_in,
  // decoded register write
  output logic reg_wr_out,
  output gdt_pkg::gdt_addr_t reg_addr_out,
  output gdt_pkg::gdt_word_t reg_data_out
);
  import gdt_pkg::*;
  // ==========================================================
  // bus idle state
  initial begin
    reg_wr_out = 1'b0;
    reg_addr_out = 4'h0;
    reg_data_out = 11'h000;
  end

  // ==========================================================
  // single write: strobe held over exactly one rising edge
  // caller keeps bridge_output_enable low around every call
  task automatic write(input gdt_addr_t addr, input gdt_word_t data);
    @(negedge clk_in);
    reg_wr_out = 1'b1;
    reg_addr_out = addr;
    reg_data_out = data;
    @(negedge clk_in);
    reg_wr_out = 1'b0;
    reg_addr_out = ~addr;
    reg_data_out = ~data;
  endtask

  // pre-charge time moved up one code per write, never skipping
  task automatic step_tpc(input int ch, input logic [7:0] upper, input int to);
    for (int c = 0; c <= to; c++) begin
      write(gdt_addr_t'(5 + ch), {1'b0, upper, c[1:0]});
    end
  endtask
endmodule

`default_nettype wire

// *** dv/gdt_config_top_tb.sv ***
// Purpose: self-checking bench of the gate-drive timing configuration bank
// Assumes: 10 MHz clock, inputs driven on the falling edge
// Notes: writes come from the host model, pwm inputs from the bench
`timescale 1ns/10ps
`default_nettype none

module gdt_config_top_tb;
  import gdt_pkg::*;
  // ==========================================================
  // signals
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] pwm = 4'h0;
  logic wr;
  gdt_addr_t addr;
  gdt_word_t data;
  logic [6:0] chan_pwm, cal_tgt;
  logic cal_en;
  gdt_cal_code_t cal_dly, cal_pc;
  gdt_cal_sel_t cal_sel;
  logic [5:0] cal_dly_cyc;
  logic [4:0] cal_pc_cyc;
  logic [13:0] src, blank, tpc;
  logic [20:0] fall, rise, pc_cyc;
  logic [41:0] blank_cyc;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;

  always #50 clk = ~clk;

  gdt_host_model host (.clk_in(clk), .reg_wr_out(wr), .reg_addr_out(addr), .reg_data_out(data));

  gdt_config_top dut (
    .core_clk_in(clk), .nrst_in(nrst), .reg_wr_in(wr), .reg_addr_in(addr), .reg_data_in(data),
    .pwm_inputs_in(pwm), .chan_pwm_out(chan_pwm), .cal_slope_end_delay_out(cal_dly),
    .cal_precharge_time_out(cal_pc), .cal_output_select_out(cal_sel), .cal_enable_out(cal_en),
    .cal_target_out(cal_tgt), .cal_delay_cycles_out(cal_dly_cyc),
    .cal_precharge_cycles_out(cal_pc_cyc), .pwm_source_select_out(src),
    .cross_conduction_blank_time_out(blank), .fall_precharge_current_out(fall),
    .rise_precharge_current_out(rise), .slope_precharge_time_out(tpc),
    .blank_cycles_out(blank_cyc), .precharge_cycles_out(pc_cyc)
  );

  // ==========================================================
  // checking and closing
  task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // hang guard, well above the roughly 130 cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      end_of_test();
    end
  end

  // ==========================================================
  // tests
  task automatic t_reset();
    chk("src", 14'h0, src);
    chk("cal_dly", {4'h0, 6'h04}, {cal_dly, cal_dly_cyc});
    chk("cal_pc", {4'h0, 5'h01}, {cal_pc, cal_pc_cyc});
    chk("cal_sel", 11'h0, {cal_sel, cal_en, cal_tgt});
    chk("blank", {14'h0, {7{6'h0a}}}, {blank, blank_cyc});
    chk("fall", 21'h0, fall);
    chk("rise", 21'h0, rise);
    chk("tpc", {14'h0, {7{3'h1}}}, {tpc, pc_cyc});
    $display("test reset done");
  endtask

  task automatic t_pwm();
    for (int c = 0; c < 4; c++) begin
      host.write(4'h3, {1'b0, {5{c[1:0]}}});
      host.write(4'h3, {1'b1, 6'h00, {2{c[1:0]}}});
      chk("src", {7{c[1:0]}}, src);
      for (int i = 0; i < 4; i++) begin
        pwm = 4'h1 << i;
        @(negedge clk);
        chk("chan_pwm", (i == c) ? 7'h7f : 7'h00, chan_pwm);
      end
    end
    $display("test pwm routing done");
  endtask

  task automatic t_cal();
    logic [3:0] k;
    for (int i = 0; i < 16; i++) begin
      k = i[3:0];
      host.write(4'h4, {k, ~k, k[2:0]});
      @(negedge clk);
      chk("cal_dly", {k, 6'(4 + 2 * i)}, {cal_dly, cal_dly_cyc});
      chk("cal_pc", {~k, 5'(16 - i)}, {cal_pc, cal_pc_cyc});
      chk("cal_sel", {k[2:0], k[2:0] != 3'h0}, {cal_sel, cal_en});
      chk("cal_tgt", (k[2:0] == 3'h0) ? 7'h0 : 7'h1 << (k[2:0] - 3'h1), cal_tgt);
    end
    $display("test calibration done");
  endtask

  task automatic t_cfg();
    logic [13:0] eb, et;
    logic [20:0] ef, er;
    logic [41:0] ebc;
    logic [20:0] epc;
    logic [2:0] c;
    eb = 14'h0;
    et = 14'h0;
    ef = 21'h0;
    er = 21'h0;
    ebc = {7{6'h0a}};
    epc = {7{3'h1}};
    for (int ch = 0; ch < 7; ch++) begin
      c = ch[2:0];
      host.step_tpc(ch, {c[1:0], c, ~c}, ch % 4);
      @(negedge clk);
      eb[2*ch +: 2] = c[1:0];
      ef[3*ch +: 3] = c;
      er[3*ch +: 3] = ~c;
      et[2*ch +: 2] = 2'(ch % 4);
      ebc[6*ch +: 6] = 6'(10 * (c[1:0] + 1));
      epc[3*ch +: 3] = 3'(ch % 4 + 1);
      chk("blank", {eb, ebc}, {blank, blank_cyc});
      chk("fall", ef, fall);
      chk("rise", er, rise);
      chk("tpc", {et, epc}, {tpc, pc_cyc});
    end
    // configuration b word and an unmapped address leave every field alone
    host.write(4'h5, 11'h7ff);
    host.write(4'hf, 11'h3ff);
    @(negedge clk);
    chk("refused", {eb, ef, er, et}, {blank, fall, rise, tpc});
    $display("test configuration a done");
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    t_reset();
    t_pwm();
    t_cal();
    t_cfg();
    end_of_test();
  end
endmodule

`default_nettype wire
